// ===== odt_zq_consts.svh
// Timing constants and field positions for the termination and calibration block
`ifndef ODT_ZQ_CONSTS_SVH
`define ODT_ZQ_CONSTS_SVH

`define CLK_PERIOD_PS      4000
`define ASYNC_MIN_PS       2000
`define ASYNC_MAX_PS       8500
`define ASYNC_MIN_CYC      ((`ASYNC_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ASYNC_MAX_CYC      (`ASYNC_MAX_PS / `CLK_PERIOD_PS)
`define DLL_FREEZE_BIT     12
`define CPDED_CYC          1
`define XPDLL_CYC          10
`define RFC_CYC            28
`define ZQINIT_CYC         512
`define ZQOPER_CYC         256
`define ZQCS_CYC           64
`define ZQ_ENGINE_CYC      48
`define CNT_W              12

`endif

// ===== odt_zq_pkg.sv
// Types for the termination and calibration block
`default_nettype none
package odt_zq_pkg;
  typedef logic [3:0] lat_t;
  typedef enum logic [1:0] {CAL_NONE, CAL_LONG, CAL_SHORT} cal_cmd_e;
endpackage
`default_nettype wire

// ===== odt_delay_line.sv
// Shift line that delays the registered termination request
`timescale 1ns/10ps
`default_nettype none
module odt_delay_line (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_odt,
  output logic      [15:0] o_taps
);
  logic [15:0] taps_r;
  assign o_taps = taps_r;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      taps_r <= 16'h0000;
    end else begin
      taps_r <= {taps_r[14:0], i_odt};
    end
  end
endmodule
`default_nettype wire

// ===== odt_zq_ctrl.sv
// Power-down termination transition windows and calibration engine
// How it works
// - Windows only when DLL freeze bit zero
// - Lead interval equals write latency minus one
// - Entry window excludes start, includes tCPDED end
// - Refresh in progress extends entry window
// - Turn-on between min and max bounds
// - Turn-off between min and max bounds
// - Synchronous response outside windows, except during frozen-DLL power-down
// - Exit window from lead to tXPDLL
// - Short power-down merges entry and exit
// - Short idle merges exit and entry
// - Long calibration updates driver and termination
// - First long within tZQinit, later tZQoper
// - Short calibration within tZQCS
// - Calibration current off after completion
// - No self recalibration on self-refresh exit
// - Asynchronous path ignores additive latency
// - Asynchronous delay between 2 and 8.5 ns
`timescale 1ns/10ps
`default_nettype none
`include "odt_zq_consts.svh"
module odt_zq_ctrl (
  input  wire logic                   i_clock,
  input  wire logic                   i_resetn,
  input  wire logic                   i_cke,
  input  wire logic                   i_odt,
  input  wire logic                   i_refresh,
  input  wire logic                   i_sr_exit,
  input  wire odt_zq_pkg::cal_cmd_e   i_cal_cmd,
  input  wire odt_zq_pkg::lat_t       i_wl,
  input  wire logic                   i_mr0_a12,
  input  wire logic                   i_async_in_window,
  input  wire logic                   i_cal_done_early,
  output logic                        o_rtt_on,
  output logic                        o_in_window,
  output logic                        o_async_mode,
  output logic                        o_cal_busy,
  output logic                        o_zq_current_on,
  output logic                        o_cal_update,
  output logic                        o_cal_timeout
);
  import odt_zq_pkg::*;

  localparam int ASYNC_DLY = (`ASYNC_MIN_CYC + `ASYNC_MAX_CYC) / 2;

  // CKE and ODT come from pins
  logic cke_s1_r, cke_s2_r, cke_d_r, odt_s1_r, odt_s2_r;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cke_s1_r <= 1'b1;
      cke_s2_r <= 1'b1;
      cke_d_r  <= 1'b1;
      odt_s1_r <= 1'b0;
      odt_s2_r <= 1'b0;
    end else begin
      cke_s1_r <= i_cke;
      cke_s2_r <= cke_s1_r;
      cke_d_r  <= cke_s2_r;
      odt_s1_r <= i_odt;
      odt_s2_r <= odt_s1_r;
    end
  end

  wire cke_fall = cke_d_r & ~cke_s2_r;
  wire cke_rise = ~cke_d_r & cke_s2_r;
  wire freeze   = ~i_mr0_a12;

  // Delayed copies of ODT for lookahead and latency
  logic [15:0] odt_taps;
  odt_delay_line u_dly (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_odt    (odt_s2_r),
    .o_taps   (odt_taps)
  );

  wire [3:0] anpd = i_wl - 4'h1;
  wire [3:0] lat  = i_wl - 4'h2;

  // Window counters, started by the synchronized CKE edges and stretched by the tANPD lead
  logic [`CNT_W-1:0] entry_cnt_r, exit_cnt_r, rfc_cnt_r;
  logic              entry_open_r, exit_open_r;
  wire  [`CNT_W-1:0] entry_len = (rfc_cnt_r > `CNT_W'(`CPDED_CYC))
                                 ? rfc_cnt_r : `CNT_W'(`CPDED_CYC);
  wire  ent_ev = cke_fall & freeze;
  wire  ext_ev = cke_rise & freeze;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rfc_cnt_r <= '0;
    end else if (i_refresh) begin
      rfc_cnt_r <= `CNT_W'(`RFC_CYC);
    end else if (rfc_cnt_r != '0) begin
      rfc_cnt_r <= rfc_cnt_r - `CNT_W'(1);
    end
  end
  // Entry window: anpd lead plus tCPDED/tRFC tail, start excluded, end included
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      entry_open_r <= 1'b0;
      entry_cnt_r  <= '0;
    end else if (ent_ev) begin
      entry_open_r <= 1'b1;
      entry_cnt_r  <= entry_len + `CNT_W'(anpd);
    end else if (entry_cnt_r != '0) begin
      entry_cnt_r  <= entry_cnt_r - `CNT_W'(1);
    end else begin
      entry_open_r <= 1'b0;
    end
  end
  // Exit window: anpd lead plus tXPDLL tail
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      exit_open_r <= 1'b0;
      exit_cnt_r  <= '0;
    end else if (ext_ev) begin
      exit_open_r <= 1'b1;
      exit_cnt_r  <= `CNT_W'(`XPDLL_CYC) + `CNT_W'(anpd);
    end else if (exit_cnt_r != '0) begin
      exit_cnt_r  <= exit_cnt_r - `CNT_W'(1);
    end else begin
      exit_open_r <= 1'b0;
    end
  end

  // Powered down with frozen DLL between windows: fully asynchronous
  logic pd_r;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pd_r <= 1'b0;
    end else if (ent_ev) begin
      pd_r <= 1'b1;
    end else if (cke_rise) begin
      pd_r <= 1'b0;
    end
  end

  // ODT is judged after an anpd delay so the window may lead the CKE edge
  wire win       = entry_open_r | exit_open_r;
  wire use_async = pd_r | (win & i_async_in_window);
  // Tap sums stay inside the line for write latency up to 9
  wire [3:0] sync_idx  = anpd + lat;
  wire [3:0] async_idx = anpd + 4'(ASYNC_DLY);
  wire sync_rtt  = odt_taps[sync_idx];
  wire async_rtt = odt_taps[async_idx];

  // Calibration engine
  logic [`CNT_W-1:0] cal_cnt_r, eng_cnt_r;
  logic              cal_busy_r, first_done_r, cur_r, upd_r, tmo_r;
  wire  [`CNT_W-1:0] cal_len = (i_cal_cmd == CAL_SHORT) ? `CNT_W'(`ZQCS_CYC)
                             : (first_done_r ? `CNT_W'(`ZQOPER_CYC)
                                             : `CNT_W'(`ZQINIT_CYC));
  wire  cal_start = (i_cal_cmd != CAL_NONE) & ~cal_busy_r;
  wire  eng_done  = cur_r & ((eng_cnt_r == '0) | i_cal_done_early);
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cal_busy_r   <= 1'b0;
      cal_cnt_r    <= '0;
      eng_cnt_r    <= '0;
      first_done_r <= 1'b0;
      cur_r        <= 1'b0;
      upd_r        <= 1'b0;
      tmo_r        <= 1'b0;
    end else begin
      upd_r <= 1'b0;
      tmo_r <= 1'b0;
      if (cal_start) begin
        cal_busy_r <= 1'b1;
        cal_cnt_r  <= cal_len - `CNT_W'(1);
        eng_cnt_r  <= `CNT_W'(`ZQ_ENGINE_CYC);
        cur_r      <= 1'b1;
        if (i_cal_cmd == CAL_LONG) begin
          first_done_r <= 1'b1;
        end
      end else if (cal_busy_r) begin
        if (eng_cnt_r != '0) begin
          eng_cnt_r <= eng_cnt_r - `CNT_W'(1);
        end
        if (eng_done) begin
          cur_r <= 1'b0;
          upd_r <= 1'b1;
        end
        if (cal_cnt_r == '0) begin
          cal_busy_r <= 1'b0;
          tmo_r      <= cur_r;
          cur_r      <= 1'b0;
        end else begin
          cal_cnt_r <= cal_cnt_r - `CNT_W'(1);
        end
      end
    end
  end

  // Termination held off for the whole calibration period
  wire rtt_nxt = cal_busy_r ? 1'b0 : (use_async ? async_rtt : sync_rtt);

  // Registered outputs
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rtt_on        <= 1'b0;
      o_in_window     <= 1'b0;
      o_async_mode    <= 1'b0;
      o_cal_busy      <= 1'b0;
      o_zq_current_on <= 1'b0;
      o_cal_update    <= 1'b0;
      o_cal_timeout   <= 1'b0;
    end else begin
      o_rtt_on        <= rtt_nxt;
      o_in_window     <= win;
      o_async_mode    <= use_async;
      o_cal_busy      <= cal_busy_r;
      o_zq_current_on <= cur_r;
      o_cal_update    <= upd_r;
      o_cal_timeout   <= tmo_r;
    end
  end
endmodule
`default_nettype wire

// ===== odt_zq_monitor.sv
// Assertion checker for the termination and calibration block
`timescale 1ns/10ps
`default_nettype none
module odt_zq_monitor (
  input wire logic                 i_clock,
  input wire logic                 i_resetn,
  input wire logic                 i_cke,
  input wire odt_zq_pkg::cal_cmd_e i_cal_cmd,
  input wire logic                 i_mr0_a12,
  input wire logic                 o_in_window,
  input wire logic                 o_async_mode,
  input wire logic                 o_cal_busy,
  input wire logic                 o_zq_current_on,
  input wire logic                 o_cal_update
);
  import odt_zq_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  property p_start; $rose(o_cal_busy) |-> $past(i_cal_cmd, 2) != CAL_NONE; endproperty
  a_start: assert property (p_start) else $error("busy without command");
  property p_pulse; o_cal_update |=> !o_cal_update; endproperty
  a_pulse: assert property (p_pulse) else $error("update too long");
  property p_inbusy; o_cal_update |-> o_cal_busy; endproperty
  a_inbusy: assert property (p_inbusy) else $error("update outside period");
  property p_engine; $rose(o_cal_busy) |-> ##[1:49] o_cal_update; endproperty
  a_engine: assert property (p_engine) else $error("update late");
  property p_curoff; o_cal_update |=> !o_zq_current_on; endproperty
  a_curoff: assert property (p_curoff) else $error("current left on");
  property p_curbusy; o_zq_current_on |-> o_cal_busy; endproperty
  a_curbusy: assert property (p_curbusy) else $error("current while idle");
  property p_freeze; i_mr0_a12 && $past(i_mr0_a12, 3) |-> !o_in_window; endproperty
  a_freeze: assert property (p_freeze) else $error("window with DLL on");
  property p_sync;
    !o_in_window && $past(i_cke, 4) && $past(i_cke, 5) |-> !o_async_mode;
  endproperty
  a_sync: assert property (p_sync) else $error("async outside window");
endmodule
bind odt_zq_ctrl odt_zq_monitor mon_u (.i_clock, .i_resetn, .i_cke, .i_cal_cmd, .i_mr0_a12,
  .o_in_window, .o_async_mode, .o_cal_busy, .o_zq_current_on, .o_cal_update);
`default_nettype wire

// ===== mc_model.sv
// Memory controller model driving CKE, ODT, refresh and calibration
`timescale 1ns/10ps
`default_nettype none
module mc_model (
  input  wire logic                 i_clock,
  output var logic                  o_cke,
  output var logic                  o_odt,
  output var logic                  o_refresh,
  output var odt_zq_pkg::cal_cmd_e  o_cmd
);
  import odt_zq_pkg::*;
  initial begin
    o_cke = 1'b1;
    o_odt = 1'b0;
    o_refresh = 1'b0;
    o_cmd = CAL_NONE;
  end
  task automatic set_odt(input logic v);
    @(negedge i_clock);
    o_odt <= v;
  endtask
  // Caller t_cal issues a second command before busy falls
  task automatic cal(input cal_cmd_e c);
    @(negedge i_clock);
    o_odt <= 1'b0;
    o_cke <= 1'b1;
    o_cmd <= c;
    @(negedge i_clock);
    o_cmd <= CAL_NONE;
  endtask
  task automatic pd(input int n, input logic rf);
    @(negedge i_clock);
    o_refresh <= rf;
    @(negedge i_clock);
    o_refresh <= 1'b0;
    o_cke <= 1'b0;
    repeat (n) @(negedge i_clock);
    o_cke <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== odt_zq_ctrl_test.sv
// Self-checking bench for the termination and calibration block
`timescale 1ns/10ps
`default_nettype none
module odt_zq_ctrl_test;
  import odt_zq_pkg::*;
  logic     i_clock, i_resetn, i_cke, i_odt, i_refresh, i_sr_exit;
  logic     i_mr0_a12, i_async_in_window, o_rtt_on, o_in_window, o_async_mode;
  logic     o_cal_busy, o_zq_current_on, o_cal_update, o_cal_timeout, i_cal_done_early;
  cal_cmd_e i_cal_cmd;
  lat_t     i_wl;
  int       fails = 0, samples_checked = 0, cyc = 0;
  mc_model ctl_u (.i_clock, .o_cke(i_cke), .o_odt(i_odt), .o_refresh(i_refresh),
    .o_cmd(i_cal_cmd));
  odt_zq_ctrl dut_u (.i_clock, .i_resetn, .i_cke, .i_odt, .i_refresh, .i_sr_exit, .i_cal_cmd,
    .i_wl, .i_mr0_a12, .i_async_in_window, .i_cal_done_early, .o_rtt_on, .o_in_window,
    .o_async_mode, .o_cal_busy, .o_zq_current_on, .o_cal_update, .o_cal_timeout);
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_sync();
    int n;
    for (int v = 1; v >= 0; v--) begin
      ctl_u.set_odt(v[0]);
      n = 0;
      while (o_rtt_on !== v[0] && n < 40) begin
        @(negedge i_clock);
        n++;
      end
      chk(16'(n), 16'(2 * i_wl + 1));
    end
    i_sr_exit <= 1'b1;
    @(negedge i_clock);
    i_sr_exit <= 1'b0;
    repeat (6) @(negedge i_clock);
    chk(16'(o_cal_busy), 16'h0);
    ctl_u.pd(20, 1'b0);
    repeat (6) @(negedge i_clock);
    chk(16'(o_in_window), 16'h0);
    chk(16'(o_async_mode), 16'h0);
    $display("t_sync done");
  endtask
  task automatic t_win(input logic r);
    int n;
    i_async_in_window <= r;
    fork
      ctl_u.pd(40, r);
      begin
        repeat (22) @(negedge i_clock);
        chk(16'(o_in_window), 16'(r));
        chk(16'(o_async_mode), 16'h1);
        for (int v = 1; v >= 0; v--) begin
          ctl_u.set_odt(v[0]);
          n = 0;
          while (o_rtt_on !== v[0] && n < 20) begin
            @(negedge i_clock);
            n++;
          end
          chk(16'(n), 16'(i_wl + 4));
        end
      end
    join
    n = 0;
    while (o_in_window !== 1'b1 && n < 10) begin
      @(negedge i_clock);
      n++;
    end
    chk(16'(n), 16'h4);
    chk(16'(o_async_mode), 16'(r));
    n = 0;
    while (o_in_window !== 1'b0 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    chk(16'(n >= 11 && n <= 15), 16'h1);
    chk(16'(o_async_mode), 16'h0);
    $display("t_win done");
  endtask
  task automatic t_cal();
    cal_cmd_e c[3] = '{CAL_LONG, CAL_LONG, CAL_SHORT};
    int       len[3] = '{512, 256, 64};
    int       n, u;
    for (int k = 0; k < 3; k++) begin
      ctl_u.cal(c[k]);
      n = 0;
      while (o_cal_busy !== 1'b1 && n < 4) begin
        @(negedge i_clock);
        n++;
      end
      ctl_u.cal(CAL_SHORT);
      i_cal_done_early <= (k == 2);
      n = 2;
      u = 0;
      while (o_cal_busy === 1'b1 && n < 600) begin
        if (o_cal_update === 1'b1) u++;
        @(negedge i_clock);
        n++;
      end
      chk(16'(n >= len[k] - 1 && n <= len[k] + 1), 16'h1);
      chk(16'(u), 16'h1);
      chk(16'(o_cal_timeout), 16'h0);
      i_cal_done_early <= 1'b0;
      repeat (4) @(negedge i_clock);
      chk(16'(o_cal_busy), 16'h0);
      chk(16'(o_zq_current_on), 16'h0);
    end
    $display("t_cal done");
  endtask
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    i_resetn = 1'b0;
    i_sr_exit = 1'b0;
    i_cal_done_early = 1'b0;
    i_mr0_a12 = 1'b1;
    i_async_in_window = 1'b1;
    i_wl = 4'h5;
    repeat (12) @(posedge i_clock);
    @(negedge i_clock);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_clock);
    t_sync();
    i_mr0_a12 = 1'b0;
    t_win(1'b0);
    t_win(1'b1);
    t_cal();
    print_verdict();
  end
endmodule
`default_nettype wire
